/* File: rtl/spi_uv_pkg.sv */
/*
  Constants shared by the serial port and undervoltage status logic:
  frame layout, command address decode, field positions, reset values
  and status select codes.
  Assumes a single 8-bit command frame format with the address in D7:D4.
*/
package spi_uv_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Frame layout
  localparam int          FRAME_BITS    = 8;
  localparam int          SYNC_STAGES   = 2;
  localparam logic [2:0]  COUNT_LAST    = 3'h7;
  localparam logic [3:0]  TX_COUNT_DONE = 4'h8;
  localparam int          ADDR_MSB      = 7;
  localparam int          ADDR_LSB      = 4;

  ////////////////////////////////////////////////////////////////////////
  // Command addresses, low three bits (D6:D4) unless full four bits
  localparam logic [2:0]  REG_STATUS    = 3'h0;
  localparam logic [2:0]  REG_OUTCTRL   = 3'h1;
  localparam logic [3:0]  REG_SUPPLY    = 4'hE;

  ////////////////////////////////////////////////////////////////////////
  // Output control fields
  localparam int          OC_ON0_BIT    = 0;
  localparam int          OC_SENSE0_BIT = 1;
  localparam int          OC_ON1_BIT    = 2;
  localparam int          OC_SENSE1_BIT = 3;
  localparam logic [3:0]  OC_RESET      = 4'h0;

  // Supply protection fields
  localparam int          SP_OVDIS_BIT  = 0;
  localparam int          SP_UVDIS_BIT  = 1;
  localparam logic        UVDIS_RESET   = 1'b0;
  localparam logic        OVDIS_RESET   = 1'b0;

  // Status select field
  localparam int          SEL_MSB       = 2;
  localparam logic [2:0]  SEL_RESET     = 3'h0;

  ////////////////////////////////////////////////////////////////////////
  // Status words selected for the next frame
  localparam logic [2:0]  SEL_FAULT     = 3'h0;
  localparam logic [2:0]  SEL_OUTCTRL   = 3'h1;
  localparam logic [2:0]  SEL_SUPPLY    = 3'h6;
  localparam int          TXF_UVF       = 0;
  localparam int          TXF_FAULTPIN  = 1;
  localparam int          TXF_GATE0     = 2;
  localparam int          TXF_GATE1     = 3;
  localparam int          TXF_DIRECT0   = 4;
  localparam int          TXF_DIRECT1   = 5;
  localparam logic [7:0]  TX_RESET      = 8'h00;

endpackage

/* File: rtl/bit_sync.sv */
/*
  Plain two-flop level synchroniser for a vector of independent bits.
  Assumes each bit is a slow level; multi-bit words are not coherent.
*/
`timescale 1ns/1ps
module bit_sync
  import spi_uv_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] async,
  output logic      [WIDTH-1:0] sync
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync;

  // First stage feeds the second stage only
  always_comb
  begin
    next_meta = async;
    next_sync = meta;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta <= '0;
      sync <= '0;
    end
    else
    begin
      meta <= next_meta;
      sync <= next_sync;
    end
  end

endmodule

/* File: rtl/spi_uv_status.sv */
/*
  Eight-bit serial slave port and undervoltage fault logic of a dual
  high-side switch. Shift logic runs on the master's serial clock; decode,
  fault and gate logic run on clk.
  Assumes the master parks sclk low around chip select edges, holds
  chip select high for four clk periods between frames, and waits four
  clk periods after chip select falls before its first sclk edge.
*/
// Behaviour
// - Receive bit shifted in on each falling serial clock edge.
// - Transmit bit advances on each rising serial clock edge after the first.
// - Deselected: clock and data ignored, serial output released.
// - Serial output driven only while chip select is low.
// - Frames are eight bits, most significant bit first.
// - Full duplex, both words shift together, MSB first.
// - Address field D7:D4 picks the target register; status and output control decode only D6:D4.
// - Outgoing word shows status, configuration or inputs chosen earlier.
// - Commanded off during undervoltage: no latch, output follows later.
// - Output command is direct pin OR serial on bit.
// - Undervoltage enabled: output off, fault bit set, fault pin low above the power-on reset level.
// - Recovery while off releases fault pin; fault bit holds until read.
// - Recovery while on keeps output off until command toggles.
// - Protection disabled: no fault report, output follows above 2.5 V.
`timescale 1ns/1ps
module spi_uv_status
  import spi_uv_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       sclk,
  input  wire logic       csN,
  input  wire logic       si,
  input  wire logic [1:0] directIn,
  input  wire logic       belowSupplyUndervoltageThreshold,
  input  wire logic       belowSupplyPowerOnResetLevel,
  input  wire logic       belowSupplyMinimum,
  output logic            so,
  output logic            soOe,
  output logic            faultPinN,
  output logic            undervoltageFaultBit,
  output logic [1:0]      gateOn,
  output logic [1:0]      currentSenseEnable,
  output logic            undervoltageProtectDisable
);

  ////////////////////////////////////////////////////////////////////////
  // Link side: shift registers on the serial clock

  logic       frameRstN;
  logic [7:0] rxShift;
  logic [7:0] next_rxShift;
  logic [2:0] rxCount;
  logic [2:0] next_rxCount;
  logic       rxWrapped;
  logic       next_rxWrapped;
  logic       frameActive;
  logic       next_frameActive;
  logic       frameTag;
  logic       next_frameTag;
  logic [3:0] txCount;
  logic [3:0] next_txCount;
  logic       soData;
  logic       next_soData;
  logic [7:0] txWord;

  // Chip select high clears frame start and transmit side without a clock edge
  assign frameRstN = nrst & ~csN;

  // Receive shift, MSB first; counts survive cs rise so clk logic can judge them
  always_comb
  begin
    next_rxShift     = csN ? rxShift : {rxShift[6:0], si};
    next_rxCount     = rxCount;
    next_rxWrapped   = rxWrapped;
    next_frameTag    = frameTag;
    next_frameActive = 1'b1;
    if (!csN)
    begin
      // First bit of a frame restarts the count and flips the frame marker
      next_rxCount   = frameActive ? 3'(rxCount + 3'h1) : 3'h1;
      next_rxWrapped = frameActive & (rxWrapped | (rxCount == COUNT_LAST));
      next_frameTag  = frameActive ? frameTag : ~frameTag;
    end
  end

  always_ff @(negedge sclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rxShift   <= 8'h00;
      rxCount   <= 3'h0;
      rxWrapped <= 1'b0;
      frameTag  <= 1'b0;
    end
    else
    begin
      rxShift   <= next_rxShift;
      rxCount   <= next_rxCount;
      rxWrapped <= next_rxWrapped;
      frameTag  <= next_frameTag;
    end
  end

  always_ff @(negedge sclk or negedge frameRstN)
  begin
    if (!frameRstN)
      frameActive <= 1'b0;
    else
      frameActive <= next_frameActive;
  end

  // Rising edge k shows bit 8-k, so the master reads bit 7 on the first fall
  always_comb
  begin
    logic [3:0] k;
    k = txCount + 4'h1;
    next_txCount = (txCount == TX_COUNT_DONE) ? TX_COUNT_DONE : k;
    if (k <= TX_COUNT_DONE)
      next_soData = txWord[3'(TX_COUNT_DONE - k)];
    else
      next_soData = rxShift[7];
  end

  always_ff @(posedge sclk or negedge frameRstN)
  begin
    if (!frameRstN)
    begin
      txCount <= 4'h0;
      soData  <= 1'b0;
    end
    else
    begin
      txCount <= next_txCount;
      soData  <= next_soData;
    end
  end

  // First bit must stand before any clock edge, so it bypasses the flop
  assign so   = (txCount == 4'h0) ? txWord[7] : soData;
  assign soOe = ~csN;

  ////////////////////////////////////////////////////////////////////////
  // Synchronised pins on clk

  logic       csSync;
  logic [1:0] directSync;
  logic       uvSync;
  logic       porSync;
  logic       minSync;

  bit_sync #(
    .WIDTH (6)
  ) bit_sync_inst (
    .clk   (clk),
    .nrst  (nrst),
    .async ({csN, directIn, belowSupplyUndervoltageThreshold,
             belowSupplyPowerOnResetLevel, belowSupplyMinimum}),
    .sync  ({csSync, directSync, uvSync, porSync, minSync})
  );

  ////////////////////////////////////////////////////////////////////////
  // Frame decode at chip select rise

  logic       csPrev;
  logic       next_csPrev;
  logic       frameValid;
  logic [3:0] ocrReg;
  logic [3:0] next_ocrReg;
  logic [2:0] statSel;
  logic [2:0] next_statSel;
  logic       uvDisable;
  logic       next_uvDisable;
  logic       ovDisable;
  logic       next_ovDisable;
  logic [3:0] addr;
  logic       lastTag;
  logic       next_lastTag;

  // Receive words are quiet by the time the synced rise is seen
  assign frameValid = csSync & ~csPrev & (frameTag ^ lastTag) & rxWrapped & (rxCount == 3'h0);
  assign addr       = rxShift[ADDR_MSB:ADDR_LSB];

  // Register writes from a complete frame only
  always_comb
  begin
    next_csPrev    = csSync;
    next_lastTag   = (csSync & ~csPrev) ? frameTag : lastTag;
    next_ocrReg    = ocrReg;
    next_statSel   = statSel;
    next_uvDisable = uvDisable;
    next_ovDisable = ovDisable;
    if (frameValid)
    begin
      if (addr[2:0] == REG_STATUS)
        next_statSel = rxShift[SEL_MSB:0];
      else if (addr[2:0] == REG_OUTCTRL)
        next_ocrReg = rxShift[3:0];
      else if (addr == REG_SUPPLY)
      begin
        next_uvDisable = rxShift[SP_UVDIS_BIT];
        next_ovDisable = rxShift[SP_OVDIS_BIT];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      csPrev    <= 1'b1;
      lastTag   <= 1'b0;
      ocrReg    <= OC_RESET;
      statSel   <= SEL_RESET;
      uvDisable <= UVDIS_RESET;
      ovDisable <= OVDIS_RESET;
    end
    else
    begin
      csPrev    <= next_csPrev;
      lastTag   <= next_lastTag;
      ocrReg    <= next_ocrReg;
      statSel   <= next_statSel;
      uvDisable <= next_uvDisable;
      ovDisable <= next_ovDisable;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Undervoltage handling per output

  logic [1:0] cmd;
  logic [1:0] uvLatch;
  logic [1:0] next_uvLatch;
  logic [1:0] next_gateOn;
  logic       uvLow;
  logic       next_faultPinN;
  logic       next_uvFault;
  logic [1:0] next_senseEn;

  assign cmd[0] = directSync[0] | ocrReg[OC_ON0_BIT];
  assign cmd[1] = directSync[1] | ocrReg[OC_ON1_BIT];
  assign uvLow  = ~uvDisable & uvSync;

  // Latch set only while commanded on; dropping the command clears it
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (!cmd[i])
        next_uvLatch[i] = 1'b0;
      else if (uvLow)
        next_uvLatch[i] = 1'b1;
      else
        next_uvLatch[i] = uvLatch[i];
      next_gateOn[i] = cmd[i] & ~minSync & (uvDisable | (~uvLow & ~uvLatch[i]));
    end
  end

  // Fault pin low in the undervoltage band or while a latch holds
  always_comb
  begin
    next_faultPinN = ~(~uvDisable & ~porSync & (uvSync | (|uvLatch)));
    // Set beats the read clear so a fresh event is never lost
    next_uvFault   = uvLow | (undervoltageFaultBit & ~frameValid);
    next_senseEn   = {ocrReg[OC_SENSE1_BIT], ocrReg[OC_SENSE0_BIT]};
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      uvLatch                    <= 2'h0;
      gateOn                     <= 2'h0;
      faultPinN                  <= 1'b1;
      undervoltageFaultBit       <= 1'b0;
      currentSenseEnable         <= 2'h0;
      undervoltageProtectDisable <= UVDIS_RESET;
    end
    else
    begin
      uvLatch                    <= next_uvLatch;
      gateOn                     <= next_gateOn;
      faultPinN                  <= next_faultPinN;
      undervoltageFaultBit       <= next_uvFault;
      currentSenseEnable         <= next_senseEn;
      undervoltageProtectDisable <= next_uvDisable;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status word, frozen while selected so the link side reads it quietly

  logic [7:0] statusWord;
  logic [7:0] next_txWord;

  // Content follows the select field of the previous status command
  always_comb
  begin
    statusWord = 8'h00;
    case (statSel)
      SEL_FAULT:
      begin
        statusWord[TXF_UVF]      = undervoltageFaultBit;
        statusWord[TXF_FAULTPIN] = faultPinN;
        statusWord[TXF_GATE0]    = gateOn[0];
        statusWord[TXF_GATE1]    = gateOn[1];
        statusWord[TXF_DIRECT0]  = directSync[0];
        statusWord[TXF_DIRECT1]  = directSync[1];
      end
      SEL_OUTCTRL:
        statusWord[3:0] = ocrReg;
      SEL_SUPPLY:
      begin
        statusWord[SP_UVDIS_BIT] = uvDisable;
        statusWord[SP_OVDIS_BIT] = ovDisable;
      end
      default:
        statusWord = 8'h00;
    endcase
    // Word follows status until the synced fall; master waits out that lag
    next_txWord = csSync ? statusWord : txWord;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      txWord <= TX_RESET;
    else
      txWord <= next_txWord;
  end

endmodule

/* File: bench/spi_uv_status_sva.sv */
/* Concurrent checks on the serial status block's ports.
   Assumes sclk only toggles inside frames; bound below. */
`timescale 1ns/1ps
module spi_uv_status_sva
(
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       sclk,
  input wire logic       csN,
  input wire logic       so,
  input wire logic       soOe,
  input wire logic       faultPinN,
  input wire logic       undervoltageFaultBit,
  input wire logic [1:0] gateOn,
  input wire logic       undervoltageProtectDisable,
  input wire logic       belowSupplyUndervoltageThreshold,
  input wire logic       belowSupplyMinimum
);
  ////////////////////////////////////////////////////////////////////////
  // Four steady clocks cover the two sync flops plus the register
  sequence s_uvHeld;
    (belowSupplyUndervoltageThreshold && !undervoltageProtectDisable) [*4];
  endsequence
  sequence s_offHeld;
    undervoltageProtectDisable [*4];
  endsequence

  // Serial output driver
  a_oe_cs: assert property (@(posedge clk) disable iff (!nrst) soOe == !csN)
    else $error("so enable does not follow chip select");
  a_oe_frame: assert property (@(negedge sclk) disable iff (!nrst) soOe)
    else $error("so not driven during a frame");
  a_so_shift: assert property (@(posedge clk) disable iff (!nrst)
    !csN && $past(!csN) && $changed(so) |-> sclk)
    else $error("so changed away from a rising sclk");

  // Undervoltage reporting
  a_uv_trip: assert property (@(posedge clk) disable iff (!nrst)
    s_uvHeld |-> gateOn == 2'h0 && undervoltageFaultBit)
    else $error("undervoltage did not trip");
  a_uvf_cause: assert property (@(posedge clk) disable iff (!nrst)
    $rose(undervoltageFaultBit) |-> $past(belowSupplyUndervoltageThreshold, 3))
    else $error("fault bit set without undervoltage");
  a_uv_off: assert property (@(posedge clk) disable iff (!nrst)
    s_offHeld |-> faultPinN && !$rose(undervoltageFaultBit))
    else $error("fault reported while protection disabled");
  a_gate_min: assert property (@(posedge clk) disable iff (!nrst)
    belowSupplyMinimum [*4] |-> gateOn == 2'h0)
    else $error("gate on below minimum supply");
  a_uvf_clear: assert property (@(posedge clk) disable iff (!nrst)
    $fell(undervoltageFaultBit) |-> csN && $past(csN, 2))
    else $error("fault bit cleared outside a frame end");
endmodule

bind spi_uv_status spi_uv_status_sva spi_uv_status_sva_inst
(
  .clk(clk), .nrst(nrst), .sclk(sclk), .csN(csN), .so(so), .soOe(soOe),
  .faultPinN(faultPinN), .undervoltageFaultBit(undervoltageFaultBit), .gateOn(gateOn),
  .undervoltageProtectDisable(undervoltageProtectDisable),
  .belowSupplyUndervoltageThreshold(belowSupplyUndervoltageThreshold),
  .belowSupplyMinimum(belowSupplyMinimum)
);

/* File: bench/spi_master_model.sv */
/* Serial master model for the block's link.
   Called by the bench; sclk parks low, si rests at its pull-down level. */
`timescale 1ns/1ps
module spi_master_model
(
  output logic     sclk,
  output logic     csN,
  output logic     si,
  input wire logic so
);
  ////////////////////////////////////////////////////////////////////////
  // Idle link: deselected, clock parked low
  initial
  begin
    sclk = 1'b0;
    csN  = 1'b1;
    si   = 1'b0;
  end

  // One frame of n bits; 80 ns serial clock
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    csN = 1'b0;
    // Four clk periods so the status word freezes behind the synced select
    #160;
    for (int i = 0; i < n; i++)
    begin
      #40;
      sclk = 1'b1;
      // Data moves on the rising edge, well away from the capturing fall
      si = tx[7-i];
      #40;
      rx = {rx[6:0], so};
      sclk = 1'b0;
    end
    #40;
    csN = 1'b1;
    si = 1'b0;
  endtask
endmodule

/* File: bench/spi_uv_status_tb_top.sv */
/* Self-checking bench for the serial status block.
   Master model drives the link; supply comparators set by the bench. */
`timescale 1ns/1ps
module spi_uv_status_tb_top;
  logic       clk;
  logic       nrst;
  logic       sclk;
  logic       csN;
  logic       si;
  logic       so;
  logic       soOe;
  logic       faultPinN;
  logic       undervoltage_fault_bit;
  logic       uvDis;
  logic       belowUv;
  logic       belowPor;
  logic       belowMin;
  logic [1:0] directIn;
  logic [1:0] gateOn;
  logic [1:0] senseEn;
  logic [7:0] rx;
  int         n_fail = 0;
  int         tests_run = 0;
  int         cycles = 0;

  ////////////////////////////////////////////////////////////////////////
  // Parts under test
  spi_uv_status spi_uv_status_inst
  (
    .clk(clk), .nrst(nrst), .sclk(sclk), .csN(csN), .si(si), .directIn(directIn),
    .belowSupplyUndervoltageThreshold(belowUv), .belowSupplyPowerOnResetLevel(belowPor),
    .belowSupplyMinimum(belowMin), .so(so), .soOe(soOe), .faultPinN(faultPinN),
    .undervoltageFaultBit(undervoltage_fault_bit), .gateOn(gateOn), .currentSenseEnable(senseEn),
    .undervoltageProtectDisable(uvDis)
  );
  spi_master_model spi_master_model_inst
  (
    .sclk(sclk), .csN(csN), .si(si), .so(so)
  );

  // 25 MHz clock and a hang guard
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared checks and stimulus
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t %s: got %h want %h", $time, msg, seen, exp);
    end
  endtask
  task automatic st(input logic [7:0] exp);
    chk({4'h0, gateOn, faultPinN, undervoltage_fault_bit}, exp, "gate and fault state");
  endtask
  // Odd offset keeps link edges clear of clk edges
  task automatic frm(input logic [7:0] tx, input int n = 8);
    @(posedge clk);
    #7;
    spi_master_model_inst.xfer(tx, n, rx);
    repeat (10) @(posedge clk);
    #1;
  endtask
  task automatic drv(input logic [1:0] d, input logic u, input logic p, input logic m);
    @(posedge clk);
    directIn <= d;
    belowUv <= u;
    belowPor <= p;
    belowMin <= m;
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    nrst = 1'b0;
    directIn = 2'h0;
    belowUv = 1'b0;
    belowPor = 1'b0;
    belowMin = 1'b0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk({3'h0, soOe, faultPinN, undervoltage_fault_bit, gateOn}, 8'h08, "reset state");
    $display("test reset done");
    frm(8'h1F);
    chk({4'h0, gateOn, senseEn}, 8'h0F, "output control");
    frm(8'h01);
    chk(rx, 8'h0E, "fault word");
    frm(8'h00);
    chk(rx, 8'h0F, "output control word");
    frm(8'h20, 7);
    st(8'h0E);
    $display("test serial done");
    // Undervoltage while commanded on, then a toggle
    drv(2'h0, 1'b1, 1'b0, 1'b0);
    st(8'h01);
    drv(2'h0, 1'b0, 1'b0, 1'b0);
    st(8'h01);
    frm(8'h10);
    st(8'h02);
    frm(8'h15);
    st(8'h0E);
    // Undervoltage while commanded off
    frm(8'h10);
    drv(2'h0, 1'b1, 1'b0, 1'b0);
    st(8'h01);
    drv(2'h0, 1'b0, 1'b0, 1'b0);
    st(8'h03);
    frm(8'h15);
    st(8'h0E);
    $display("test latch done");
    // Command from the direct pin only
    frm(8'h10);
    drv(2'h2, 1'b0, 1'b0, 1'b0);
    st(8'h0A);
    drv(2'h2, 1'b1, 1'b0, 1'b0);
    st(8'h01);
    drv(2'h2, 1'b0, 1'b0, 1'b0);
    st(8'h01);
    drv(2'h0, 1'b0, 1'b0, 1'b0);
    st(8'h03);
    drv(2'h2, 1'b0, 1'b0, 1'b0);
    st(8'h0B);
    drv(2'h0, 1'b1, 1'b1, 1'b0);
    st(8'h03);
    $display("test direct done");
    // Protection disabled; only the full four-bit address reaches it
    drv(2'h0, 1'b0, 1'b0, 1'b0);
    frm(8'h62);
    chk({7'h0, uvDis}, 8'h00, "near address");
    frm(8'hE2);
    chk({7'h0, uvDis}, 8'h01, "disable set");
    frm(8'h06);
    frm(8'h00);
    chk(rx, 8'h02, "supply word");
    drv(2'h3, 1'b1, 1'b0, 1'b0);
    st(8'h0E);
    drv(2'h3, 1'b1, 1'b0, 1'b1);
    st(8'h02);
    $display("test disable done");
    finish_test();
  end
endmodule
